//--- src/adccr_pkg.sv
// package: register map, field layout and sizes of the request logic
package adccr_pkg;
  localparam int MOD0_CH = 16;
  localparam int MOD1_CH = 8;
  localparam int NCH     = 24;               // mod0 in 0..15, mod1 in 16..23
  localparam int NMOD    = 2;
  localparam logic [23:0] DMA_CAPABLE = 24'h00800F; // mod0 ch0..3 and ch15
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;  // scan irq enable, dma sel
  localparam logic [7:0] OFS_SFLAG   = 8'h04;  // scan end flags / clear
  localparam logic [7:0] OFS_CHEN    = 8'h08;  // channel irq enables
  localparam logic [7:0] OFS_CHDMA   = 8'h0C;  // channel dma select
  localparam logic [7:0] OFS_CHFLAG  = 8'h10;  // channel done flags / clear
  localparam logic [7:0] OFS_ACTIVE  = 8'h14;  // scan / intr-conv active
  localparam logic [7:0] OFS_PINMODE = 8'h18;  // per-module digital use
  // control and active register fields
  localparam int CTRL_IE_LSB  = 0;   // scan_end_irq_enable, 2 bits
  localparam int CTRL_DMA_LSB = 8;   // scan dma select, 2 bits
  localparam int ACT_SCAN_LSB = 0;   // scan_active_bit, 2 bits
  localparam int ACT_INTR_LSB = 8;   // intr_conv_active_bit, 2 bits
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO32     = 32'h00000000;
endpackage

//--- src/adccr_flagbank.sv
// flag bank: sticky completion flags with set, soft clear and dma clear
`timescale 1ns/1ps
module adccr_flagbank #(
  parameter int W = 24
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] soft_clr_i,
  input  wire logic [W-1:0] dma_clr_i,
  output logic      [W-1:0] flag_q
);
  // **********************************************************
  // per-bit flag, set wins over any clear in the same cycle
  // **********************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag_q[g] <= 1'b0;
        end else if (set_i[g]) begin
          flag_q[g] <= 1'b1;
        end else if (soft_clr_i[g] || dma_clr_i[g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

//--- src/adccr_top.sv
// top: converter completion request logic with axi4-lite registers
// Behaviour
// - scan-end cpu request passes only while its enable bit is 1
// - scan-end routed to dma goes to dma, never to cpu interrupt
// - dma acceptance of scan-end request clears the scan-end flag
// - cpu interrupt leaves scan-end flag set; only software clears it
// - every channel of both modules has its own request enable bit
// - only mod0 channels 0-3,15 may use dma; acceptance clears flag
// - cpu interrupt never clears a channel completion flag
// - scan completion sets scan-end flag and clears scan-active
// - conversion completion sets channel flag, clears intr-active
`timescale 1ns/1ps
module adccr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  scan_start,
  input  wire logic [1:0]  scan_done,
  input  wire logic [1:0]  intr_start,
  input  wire logic [23:0] chan_done,
  output logic [1:0]       scan_end_irq,
  output logic [15:0]      mod0_chan_conv_end_irq,
  output logic [7:0]       mod1_chan_conv_end_irq,
  output logic             irq,
  output logic [1:0]       scan_dma_req,
  output logic [23:0]      chan_dma_req,
  input  wire logic [1:0]  scan_dma_ack,
  input  wire logic [23:0] chan_dma_ack
);
  localparam int N = adccr_pkg::NCH;

  // **********************************************************
  // register state
  // **********************************************************
  logic [1:0]   scan_end_irq_enable_r;
  logic [1:0]   scan_dma_sel_r;
  logic [N-1:0] chan_irq_enable_reg_r;
  logic [N-1:0] chan_dma_sel_r;
  logic [1:0]   pin_digital_r;
  logic [1:0]   scan_active_bit_r;
  logic [1:0]   intr_conv_active_bit_r;
  logic [1:0]   scan_end_flag_reg;
  logic [N-1:0] chan_done_flag;
  logic [1:0]   scan_soft_clr;
  logic [N-1:0] chan_soft_clr;
  logic [N-1:0] chan_dma_ok;

  // non-capable channels can never route to dma
  assign chan_dma_ok = chan_dma_sel_r & adccr_pkg::DMA_CAPABLE;

  // **********************************************************
  // axi4-lite write channel
  // **********************************************************
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic       wr_go;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      adccr_pkg::OFS_CTRL, adccr_pkg::OFS_SFLAG, adccr_pkg::OFS_CHEN,
      adccr_pkg::OFS_CHDMA, adccr_pkg::OFS_CHFLAG, adccr_pkg::OFS_ACTIVE,
      adccr_pkg::OFS_PINMODE: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  // address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= adccr_pkg::ZERO32;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adccr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(awaddr_r) ? adccr_pkg::RESP_OKAY
                                              : adccr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // **********************************************************
  // writable configuration; wstrb ignored, whole-word writes only
  // **********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_end_irq_enable_r <= 2'h0;
      scan_dma_sel_r        <= 2'h0;
      chan_irq_enable_reg_r <= 24'h000000;
      chan_dma_sel_r        <= 24'h000000;
      pin_digital_r         <= 2'h0;
    end else if (wr_go) begin
      case (awaddr_r)
        adccr_pkg::OFS_CTRL: begin
          scan_end_irq_enable_r <= wdata_r[adccr_pkg::CTRL_IE_LSB +: 2];
          scan_dma_sel_r        <= wdata_r[adccr_pkg::CTRL_DMA_LSB +: 2];
        end
        adccr_pkg::OFS_CHEN:    chan_irq_enable_reg_r <= wdata_r[N-1:0];
        adccr_pkg::OFS_CHDMA:   chan_dma_sel_r <= wdata_r[N-1:0];
        // one bit per module: whole module analog or digital
        adccr_pkg::OFS_PINMODE: pin_digital_r <= wdata_r[1:0];
        default: ;
      endcase
    end
  end

  // write-one-to-clear strobes for the flag registers
  assign scan_soft_clr = (wr_go && awaddr_r == adccr_pkg::OFS_SFLAG)
                         ? wdata_r[1:0] : 2'h0;
  assign chan_soft_clr = (wr_go && awaddr_r == adccr_pkg::OFS_CHFLAG)
                         ? wdata_r[N-1:0] : 24'h000000;

  // **********************************************************
  // completion flags; dma acceptance clears, cpu delivery does not
  // **********************************************************
  adccr_flagbank #(.W(2)) u_scan_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_i      (scan_done),
    .soft_clr_i (scan_soft_clr),
    .dma_clr_i  (scan_dma_ack & scan_dma_req & scan_dma_sel_r),
    .flag_q     (scan_end_flag_reg)
  );

  adccr_flagbank #(.W(N)) u_chan_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_i      (chan_done),
    .soft_clr_i (chan_soft_clr),
    .dma_clr_i  (chan_dma_ack & chan_dma_req & chan_dma_ok),
    .flag_q     (chan_done_flag)
  );

  // **********************************************************
  // activity indications: start sets, completion clears
  // **********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_active_bit_r      <= 2'h0;
      intr_conv_active_bit_r <= 2'h0;
    end else begin
      scan_active_bit_r <= (scan_active_bit_r | scan_start) & ~scan_done;
      intr_conv_active_bit_r <=
        (intr_conv_active_bit_r | intr_start) &
        ~{|chan_done[N-1:adccr_pkg::MOD0_CH],
          |chan_done[adccr_pkg::MOD0_CH-1:0]};
    end
  end

  // **********************************************************
  // request routing: cpu path gated by enable, dma path held
  // **********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_end_irq           <= 2'h0;
      mod0_chan_conv_end_irq <= 16'h0000;
      mod1_chan_conv_end_irq <= 8'h00;
      irq                    <= 1'b0;
      scan_dma_req           <= 2'h0;
      chan_dma_req           <= 24'h000000;
    end else begin
      // dma-routed sources never reach the cpu
      scan_end_irq <= scan_end_flag_reg & scan_end_irq_enable_r
                      & ~scan_dma_sel_r;
      {mod1_chan_conv_end_irq, mod0_chan_conv_end_irq} <=
        chan_done_flag & chan_irq_enable_reg_r & ~chan_dma_ok;
      irq <= |(scan_end_flag_reg & scan_end_irq_enable_r & ~scan_dma_sel_r)
           | |(chan_done_flag & chan_irq_enable_reg_r & ~chan_dma_ok);
      // request drops the edge after acceptance, flag cleared with it
      scan_dma_req <= scan_end_flag_reg & scan_dma_sel_r
                      & ~(scan_dma_ack & scan_dma_req);
      chan_dma_req <= chan_done_flag & chan_dma_ok
                      & ~(chan_dma_ack & chan_dma_req);
    end
  end

  // **********************************************************
  // axi4-lite read channel
  // **********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= adccr_pkg::ZERO32;
      s_axi_rresp   <= adccr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_mapped(s_axi_araddr) ? adccr_pkg::RESP_OKAY
                                                  : adccr_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          adccr_pkg::OFS_CTRL: s_axi_rdata <= {22'h000000,
            scan_dma_sel_r, 6'h00, scan_end_irq_enable_r};
          adccr_pkg::OFS_SFLAG:  s_axi_rdata <= {30'h00000000,
            scan_end_flag_reg};
          adccr_pkg::OFS_CHEN:   s_axi_rdata <= {8'h00,
            chan_irq_enable_reg_r};
          adccr_pkg::OFS_CHDMA:  s_axi_rdata <= {8'h00, chan_dma_ok};
          adccr_pkg::OFS_CHFLAG: s_axi_rdata <= {8'h00, chan_done_flag};
          adccr_pkg::OFS_ACTIVE: s_axi_rdata <= {22'h000000,
            intr_conv_active_bit_r, 6'h00, scan_active_bit_r};
          adccr_pkg::OFS_PINMODE: s_axi_rdata <= {30'h00000000,
            pin_digital_r};
          default: s_axi_rdata <= adccr_pkg::ZERO32;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // **********************************************************
  // checks
  // **********************************************************
  // keep and hold checks also look at the flag itself: the registered
  // request lags one cycle, so a soft clear may already have dropped it
  a_scan_irq_gate:
    assert property (@(posedge aclk) disable iff (!aresetn)
      scan_end_irq[0] |-> $past(scan_end_irq_enable_r[0]))
    else $error("scan irq without enable");
  a_scan_dma_excl:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $past(scan_dma_sel_r[0]) |-> !scan_end_irq[0])
    else $error("dma-routed scan reached cpu");
  a_scan_dma_clr:
    assert property (@(posedge aclk) disable iff (!aresetn)
      scan_dma_ack[0] && scan_dma_req[0] && scan_dma_sel_r[0]
      && !scan_done[0] |=> !scan_end_flag_reg[0])
    else $error("scan flag not cleared by dma");
  a_scan_keep:
    assert property (@(posedge aclk) disable iff (!aresetn)
      scan_end_irq[0] && scan_end_flag_reg[0] && !scan_soft_clr[0]
      |=> scan_end_flag_reg[0])
    else $error("scan flag lost on cpu irq");
  a_chan_gate:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mod0_chan_conv_end_irq[4] |-> $past(chan_irq_enable_reg_r[4]))
    else $error("chan irq without enable");
  a_dma_capable:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_dma_req & ~adccr_pkg::DMA_CAPABLE) == 24'h000000)
    else $error("dma request on incapable channel");
  a_chan_keep:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mod0_chan_conv_end_irq[4] && chan_done_flag[4] && !chan_soft_clr[4]
      |=> chan_done_flag[4])
    else $error("chan flag lost on cpu irq");
  a_scan_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      scan_done[0] |=> scan_end_flag_reg[0] && !scan_active_bit_r[0])
    else $error("scan completion not recorded");
  a_chan_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      chan_done[16] |=> chan_done_flag[16] && !intr_conv_active_bit_r[1])
    else $error("chan completion not recorded");
  a_dma_hold:
    assert property (@(posedge aclk) disable iff (!aresetn)
      chan_dma_req[0] && chan_done_flag[0] && !chan_dma_ack[0]
      && chan_dma_ok[0] && !chan_soft_clr[0] |=> chan_dma_req[0])
    else $error("dma request dropped before accept");
  a_scan_dma_hold:
    assert property (@(posedge aclk) disable iff (!aresetn)
      scan_dma_req[0] && scan_end_flag_reg[0] && !scan_dma_ack[0]
      && scan_dma_sel_r[0] && !scan_soft_clr[0] |=> scan_dma_req[0])
    else $error("scan dma request dropped before accept");
endmodule

//--- tb/adccr_dma_model.sv
// dma controller model: accepts held transfer requests after a delay
`timescale 1ns/1ps
module adccr_dma_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  ack_delay,
  input  wire logic [1:0]  scan_dma_req,
  input  wire logic [23:0] chan_dma_req,
  output logic      [1:0]  scan_dma_ack,
  output logic      [23:0] chan_dma_ack
);
  logic [3:0] wait_r;
  // waiting time of pending requests; a long delay shows the request holds
  always_ff @(posedge aclk) begin
    if (!aresetn || (scan_dma_req == 2'h0 && chan_dma_req == 24'h000000)) begin
      wait_r <= 4'h0;
    end else if (wait_r != 4'hF) begin
      wait_r <= wait_r + 4'h1;
    end
  end
  // one-cycle acceptance, given only to requests that are still raised
  always_ff @(posedge aclk) begin
    if (aresetn && wait_r >= ack_delay && scan_dma_ack == 2'h0
        && chan_dma_ack == 24'h000000) begin
      scan_dma_ack <= scan_dma_req;
      chan_dma_ack <= chan_dma_req;
    end else begin
      scan_dma_ack <= 2'h0;
      chan_dma_ack <= 24'h000000;
    end
  end
endmodule

//--- tb/test_adc_completion_request_logic.sv
// testbench: completion requests, cpu and dma routing, register access
`timescale 1ns/1ps
module test_adc_completion_request_logic;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, ack_delay = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, scan_end_irq;
  logic [1:0] scan_dma_req, scan_dma_ack;
  logic [1:0] scan_start = 2'h0, scan_done = 2'h0, intr_start = 2'h0;
  logic [23:0] chan_done = 24'h0, chan_dma_req, chan_dma_ack;
  logic [15:0] mod0_chan_conv_end_irq;
  logic [7:0] mod1_chan_conv_end_irq;
  logic [31:0] rd_d;
  logic [1:0] rsp;
  int err_total = 0, total_checks = 0;
  adccr_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scan_start(scan_start),
    .scan_done(scan_done), .intr_start(intr_start), .chan_done(chan_done),
    .scan_end_irq(scan_end_irq), .irq(irq),
    .mod0_chan_conv_end_irq(mod0_chan_conv_end_irq),
    .mod1_chan_conv_end_irq(mod1_chan_conv_end_irq),
    .scan_dma_req(scan_dma_req), .chan_dma_req(chan_dma_req),
    .scan_dma_ack(scan_dma_ack), .chan_dma_ack(chan_dma_ack));
  adccr_dma_model dma_u (.aclk(aclk), .aresetn(aresetn), .ack_delay(ack_delay),
    .scan_dma_req(scan_dma_req), .chan_dma_req(chan_dma_req),
    .scan_dma_ack(scan_dma_ack), .chan_dma_ack(chan_dma_ack));
  // 50 MHz clock
  always #10 aclk = ~aclk;
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // handshakes are judged mid-cycle, where registered readies are settled;
  // no cycle limit here: a hung slave is left to the watchdog
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (!s_axi_awvalid && !s_axi_wvalid && !s_axi_bready) break;
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bready & s_axi_bvalid;
      if (b_hit) rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (!s_axi_arvalid && !s_axi_rready) break;
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rready & s_axi_rvalid;
      if (r_hit) begin
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
      end
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    check_val(rd_d, exp);
  endtask
  // one-cycle event pulse: 0 scan start, 1 scan done, 2 intr start, 3 chan
  task automatic pulse_in(input int sel, input int idx, input int gap);
    @(posedge aclk);
    case (sel)
      0: scan_start[idx] <= 1'b1;
      1: scan_done[idx] <= 1'b1;
      2: intr_start[idx] <= 1'b1;
      default: chan_done[idx] <= 1'b1;
    endcase
    @(posedge aclk);
    scan_start <= 2'h0; scan_done <= 2'h0;
    intr_start <= 2'h0; chan_done <= 24'h0;
    repeat (gap) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic t_scan_cpu();
    @(negedge aclk);
    check_val({31'h0, irq}, 32'h0);
    rd_chk(adccr_pkg::OFS_CTRL, 32'h0);
    axi_wr(adccr_pkg::OFS_CTRL, 32'h00000001);
    pulse_in(0, 0, 1);
    rd_chk(adccr_pkg::OFS_ACTIVE, 32'h00000001);
    pulse_in(1, 0, 3);
    check_val({30'h0, scan_end_irq}, 32'h1);
    check_val({31'h0, irq}, 32'h1);
    rd_chk(adccr_pkg::OFS_ACTIVE, 32'h0);
    rd_chk(adccr_pkg::OFS_SFLAG, 32'h00000001);
    axi_wr(adccr_pkg::OFS_SFLAG, 32'h00000001);
    repeat (3) @(negedge aclk);
    check_val({31'h0, irq}, 32'h0);
    pulse_in(1, 1, 3); // module 1 has its enable at 0
    check_val({29'h0, scan_end_irq, irq}, 32'h0);
    rd_chk(adccr_pkg::OFS_SFLAG, 32'h00000002);
    axi_wr(adccr_pkg::OFS_SFLAG, 32'h00000002);
  endtask
  // a slow acceptor shows the request holding; the cpu enable stays on
  // to show that dma routing overrides it
  task automatic t_scan_dma();
    ack_delay <= 4'h6;
    axi_wr(adccr_pkg::OFS_CTRL, 32'h00000101);
    pulse_in(1, 0, 3);
    check_val({30'h0, scan_dma_req}, 32'h1);
    check_val({29'h0, scan_end_irq, irq}, 32'h0);
    repeat (12) @(negedge aclk);
    check_val({30'h0, scan_dma_req}, 32'h0);
    rd_chk(adccr_pkg::OFS_SFLAG, 32'h0);
  endtask
  task automatic t_chan();
    int caps[5] = '{0, 1, 2, 3, 15};
    axi_wr(adccr_pkg::OFS_CHEN, 32'h00FFFFFF);
    axi_wr(adccr_pkg::OFS_CHDMA, 32'h0000801F);
    rd_chk(adccr_pkg::OFS_CHDMA, 32'h0000800F);
    // slow acceptor still set: the channel request must stand until taken
    pulse_in(3, 15, 3);
    check_val({8'h0, chan_dma_req}, 32'h00008000);
    repeat (12) @(negedge aclk);
    check_val({8'h0, chan_dma_req}, 32'h0);
    ack_delay <= 4'h0;
    foreach (caps[k]) begin
      pulse_in(3, caps[k], 8);
      check_val({31'h0, irq}, 32'h0);
      rd_chk(adccr_pkg::OFS_CHFLAG, 32'h0);
    end
    pulse_in(3, 4, 3); // channel 4 cannot reach the dma side
    check_val({16'h0, mod0_chan_conv_end_irq}, 32'h00000010);
    rd_chk(adccr_pkg::OFS_CHFLAG, 32'h00000010);
    axi_wr(adccr_pkg::OFS_CHFLAG, 32'h00000010);
    pulse_in(2, 1, 1);
    rd_chk(adccr_pkg::OFS_ACTIVE, 32'h00000200);
    pulse_in(3, 17, 3);
    check_val({24'h0, mod1_chan_conv_end_irq}, 32'h00000002);
    rd_chk(adccr_pkg::OFS_ACTIVE, 32'h0);
    rd_chk(adccr_pkg::OFS_CHFLAG, 32'h00020000);
    axi_wr(adccr_pkg::OFS_CHEN, 32'h0);
    repeat (3) @(negedge aclk);
    check_val({23'h0, mod1_chan_conv_end_irq, irq}, 32'h0);
    axi_wr(adccr_pkg::OFS_CHFLAG, 32'h00020000);
  endtask
  task automatic t_regs();
    axi_wr(adccr_pkg::OFS_PINMODE, 32'h00000001);
    check_val({30'h0, rsp}, {30'h0, adccr_pkg::RESP_OKAY});
    rd_chk(adccr_pkg::OFS_PINMODE, 32'h00000001);
    check_val({30'h0, rsp}, {30'h0, adccr_pkg::RESP_OKAY});
    rd_chk(8'h1C, 32'h0);
    check_val({30'h0, rsp}, {30'h0, adccr_pkg::RESP_SLVERR});
    axi_wr(8'h1C, 32'h0000FFFF);
    check_val({30'h0, rsp}, {30'h0, adccr_pkg::RESP_SLVERR});
  endtask
  // about 250 cycles of tests; the watchdog leaves ample margin
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_scan_cpu();
    t_scan_dma();
    t_chan();
    t_regs();
    stop_test();
  end
endmodule
